// [rtl/cpvg_defs.svh]
`ifndef CPVG_DEFS_SVH
`define CPVG_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CPVG_CLK_MHZ      200
`define CPVG_WAKE_MAX_US  1800
`define CPVG_WAKE_CYC     (`CPVG_WAKE_MAX_US * `CPVG_CLK_MHZ)
`define CPVG_WAKE_W       20

// ----------------------------------------------------------------
// sampling counts
// ----------------------------------------------------------------
`define CPVG_PD_SAMPLES   2'h2

`endif

// [rtl/cpvg_pkg.sv]
package cpvg_pkg;

    // power sequencing states, one-hot
    typedef enum logic [4:0] {
        CPVG_PG_WAIT = 5'h01,
        CPVG_RUN     = 5'h02,
        CPVG_PARK    = 5'h04,
        CPVG_DOWN    = 5'h08,
        CPVG_WAKE    = 5'h10
    } cpvg_pwr_t;

endpackage

// [rtl/cpvg_sync.sv]
`timescale 1ns/1ps

module cpvg_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // level in and out
    input  wire logic din,
    output logic      dout
);

    logic meta;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// [rtl/cpvg_ctrl.sv]
`timescale 1ns/1ps
`include "cpvg_defs.svh"

module cpvg_ctrl #(
    parameter int WAKE_LIMIT = `CPVG_WAKE_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // control pins
    input  wire logic powerGoodOrDownPin,
    input  wire logic videoClkStopN,
    // internal clock sources
    input  wire logic cpuClkIn,
    input  wire logic seClkIn,
    input  wire logic diffClkIn,
    input  wire logic vid27In,
    input  wire logic vidSsIn,
    input  wire logic vidNssIn,
    input  wire logic pllLocked,
    // gated clock outputs
    output logic      seClkOut,
    output logic      vidSsOut,
    output logic      vidNssOut,
    output logic      diffTrueOut,
    output logic      diffCompOut,
    output logic      diffOe,
    // oscillator control and status
    output logic      vcoEnable,
    output logic      xtalEnable,
    output logic      powerGood,
    output logic      wakeOverrun
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    function automatic logic rose(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

    cpvg_pkg::cpvg_pwr_t state;
    cpvg_pkg::cpvg_pwr_t next_state;

    logic                   pinSync;
    logic                   cpuPrev;
    logic                   sePrev;
    logic                   vidPrev;
    logic [1:0]             cpuLowCnt;
    logic                   pdReq;
    logic                   parkReq;
    logic                   seGate;
    logic                   vidPwrGate;
    logic                   diffRun;
    logic                   vidRun;
    logic                   vidSmp;
    logic [`CPVG_WAKE_W-1:0] wakeCnt;
    logic                   cpuRise;
    logic                   seFall;
    logic                   vidFall;
    logic                   allOn;
    logic                   allOff;

    // ----------------------------------------------------------------
    // pin synchroniser and edge detection
    // ----------------------------------------------------------------
    cpvg_sync cpvg_sync_inst (
        .sys_clk (sys_clk),
        .srst    (srst),
        .din     (powerGoodOrDownPin),
        .dout    (pinSync)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpuPrev <= 1'b0;
            sePrev  <= 1'b0;
            vidPrev <= 1'b0;
        end else begin
            cpuPrev <= cpuClkIn;
            sePrev  <= seClkIn;
            vidPrev <= vid27In;
        end
    end

    assign cpuRise = rose(cpuPrev, cpuClkIn);
    assign seFall  = fell(sePrev, seClkIn);
    assign vidFall = fell(vidPrev, vid27In);
    assign allOn   = seGate & vidPwrGate & diffRun;
    assign allOff  = ~seGate & ~vidPwrGate & ~diffRun;

    // ----------------------------------------------------------------
    // power-down request: two successive low cpu-edge samples
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpuLowCnt <= 2'h0;
        end else if (pinSync || !powerGood) begin
            cpuLowCnt <= 2'h0;
        end else if (cpuRise && cpuLowCnt != `CPVG_PD_SAMPLES) begin
            cpuLowCnt <= cpuLowCnt + 2'h1;
        end
    end

    // stale count must not outlive a release
    assign pdReq   = (cpuLowCnt == `CPVG_PD_SAMPLES) && !pinSync;
    // a release while parking still finishes the park
    assign parkReq = pdReq | (state == cpvg_pkg::CPVG_PARK);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            powerGood <= 1'b0;
        end else if (state == cpvg_pkg::CPVG_PG_WAIT && pinSync) begin
            powerGood <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // power sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            cpvg_pkg::CPVG_PG_WAIT: begin
                if (pinSync) begin
                    next_state = cpvg_pkg::CPVG_WAKE;
                end
            end
            cpvg_pkg::CPVG_WAKE: begin
                if (pdReq) begin
                    next_state = cpvg_pkg::CPVG_PARK;
                end else if (allOn) begin
                    next_state = cpvg_pkg::CPVG_RUN;
                end
            end
            cpvg_pkg::CPVG_RUN: begin
                if (pdReq) begin
                    next_state = cpvg_pkg::CPVG_PARK;
                end
            end
            cpvg_pkg::CPVG_PARK: begin
                if (allOff) begin
                    next_state = cpvg_pkg::CPVG_DOWN;
                end
            end
            cpvg_pkg::CPVG_DOWN: begin
                if (pinSync) begin
                    next_state = cpvg_pkg::CPVG_WAKE;
                end
            end
            default: next_state = cpvg_pkg::CPVG_PG_WAIT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= cpvg_pkg::CPVG_PG_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // oscillators stop only once every output is parked
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vcoEnable  <= 1'b1;
            xtalEnable <= 1'b1;
        end else if (state == cpvg_pkg::CPVG_PARK && allOff) begin
            vcoEnable  <= 1'b0;
            xtalEnable <= 1'b0;
        end else if (state == cpvg_pkg::CPVG_DOWN && pinSync) begin
            vcoEnable  <= 1'b1;
            xtalEnable <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // output gates
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seGate <= 1'b0;
        end else if (parkReq && seFall) begin
            seGate <= 1'b0;
        end else if (state == cpvg_pkg::CPVG_WAKE && !pdReq && pllLocked && !seClkIn) begin
            seGate <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vidPwrGate <= 1'b0;
        end else if (parkReq && vidFall) begin
            vidPwrGate <= 1'b0;
        end else if (state == cpvg_pkg::CPVG_WAKE && !pdReq && pllLocked && !vid27In) begin
            vidPwrGate <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            diffRun <= 1'b0;
        end else if (parkReq) begin
            diffRun <= 1'b0;
        end else if (state == cpvg_pkg::CPVG_WAKE && pllLocked && !diffClkIn) begin
            diffRun <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // video stop, sampled on 27M falling edges
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vidSmp <= 1'b1;
            vidRun <= 1'b1;
        end else if (vidFall) begin
            vidSmp <= videoClkStopN;
            if (!vidSmp && !videoClkStopN) begin
                vidRun <= 1'b0;
            end else if (videoClkStopN) begin
                vidRun <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered clock outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seClkOut  <= 1'b0;
            vidSsOut  <= 1'b0;
            vidNssOut <= 1'b0;
        end else begin
            seClkOut  <= seClkIn & seGate;
            vidSsOut  <= vidSsIn & vidPwrGate & vidRun;
            vidNssOut <= vidNssIn & vidPwrGate & vidRun;
        end
    end

    // differential: driven low while parked, released when down, high on wake
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            diffTrueOut <= 1'b0;
            diffCompOut <= 1'b0;
            diffOe      <= 1'b1;
        end else begin
            diffOe      <= (next_state != cpvg_pkg::CPVG_DOWN);
            diffTrueOut <= diffRun ? diffClkIn
                                   : (state == cpvg_pkg::CPVG_WAKE
                                      && next_state == cpvg_pkg::CPVG_WAKE);
            diffCompOut <= diffRun & ~diffClkIn;
        end
    end

    // ----------------------------------------------------------------
    // wake latency watch
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wakeCnt     <= '0;
            wakeOverrun <= 1'b0;
        end else if (state != cpvg_pkg::CPVG_WAKE) begin
            wakeCnt <= '0;
        end else if (wakeCnt == WAKE_LIMIT[`CPVG_WAKE_W-1:0]) begin
            wakeOverrun <= 1'b1;
        end else begin
            wakeCnt <= wakeCnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_pd_after_pg: assert property ((state == cpvg_pkg::CPVG_PARK) |-> powerGood)
        else $error("power-down entered before power-good");
    a_osc_after_park: assert property ($fell(vcoEnable) |-> allOff && !seClkOut)
        else $error("oscillators stopped before outputs parked");
    a_diff_hold_low: assert property (pdReq |=> !diffRun ##1 !diffTrueOut && !diffCompOut)
        else $error("differential not held low on power-down");
    a_se_stop_fall: assert property ($fell(seGate) |-> $past(sePrev && !seClkIn))
        else $error("single-ended output stopped off a falling edge");
    a_wake_start: assert property ((state == cpvg_pkg::CPVG_DOWN && pinSync)
        |=> vcoEnable && state == cpvg_pkg::CPVG_WAKE ##1 diffOe && diffTrueOut)
        else $error("release did not start wake with diff high");
    a_video_only: assert property ((!vidRun && seGate) |=> seClkOut == $past(seClkIn))
        else $error("video stop disturbed other outputs");
    a_video_stop: assert property ((vidFall && !vidSmp && !videoClkStopN)
        |=> !vidRun ##1 (!vidSsOut && !vidNssOut))
        else $error("video outputs not stopped low");
    a_video_resume: assert property ((vidFall && videoClkStopN) |=> vidRun)
        else $error("video outputs not resumed");
    a_run_enabled: assert property ((state == cpvg_pkg::CPVG_RUN) |-> allOn)
        else $error("running with an output still gated");

endmodule

// [tb/cpvg_pwr_model.sv]
`timescale 1ns/1ps

module cpvg_pwr_model #(
    parameter int PD_DELAY = 400
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // requests from the bench
    input  wire logic pgReq,
    input  wire logic pdReq,
    input  wire logic initPd,
    input  wire logic vidStopReq,
    // control pins
    output logic      powerGoodOrDownPin = 1'b0,
    output logic      videoClkStopN      = 1'b1
);
    int pgCnt = 0;

    // ----------------------------------------------------------------
    // pins move on the falling edge only
    // ----------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (srst) begin
            pgCnt <= 0;
        end else if (pgReq && pgCnt < PD_DELAY) begin
            pgCnt <= pgCnt + 1;
        end
        powerGoodOrDownPin <= pgReq && !pdReq && !(initPd && pgCnt >= PD_DELAY);
        videoClkStopN      <= !vidStopReq;
    end
endmodule

// [tb/tb_clock_power_down_and_video_gate.sv]
`timescale 1ns/1ps

module tb_clock_power_down_and_video_gate;
    logic sysClk = 1'b0;
    logic srst = 1'b1;
    logic cpuClkIn = 1'b0, seClkIn = 1'b0, diffClkIn = 1'b0, vid27In = 1'b0;
    logic pllLocked = 1'b0;
    logic pgReq = 1'b0, pdReq = 1'b0, initPd = 1'b0, vidStopReq = 1'b0;
    logic powerGoodOrDownPin, videoClkStopN;
    logic seClkOut, vidSsOut, vidNssOut, diffTrueOut, diffCompOut, diffOe;
    logic vcoEnable, xtalEnable, powerGood, wakeOverrun;
    int   nMismatch = 0;
    int   totalChecks = 0;
    int   ph = 0;
    int   cycles = 0;
    int   seLen = 0;
    int   vidLen = 0;

    always #2.5 sysClk = ~sysClk;

    // ----------------------------------------------------------------
    // source clocks and instances
    // ----------------------------------------------------------------
    always @(negedge sysClk) begin
        ph        <= ph + 1;
        cpuClkIn  <= ph[1];
        diffClkIn <= ph[1];
        vid27In   <= ph[2];
        seClkIn   <= (ph % 6) >= 3;
    end

    cpvg_pwr_model cpvg_pwr_model_inst (.sys_clk(sysClk), .srst(srst), .pgReq(pgReq),
        .pdReq(pdReq), .initPd(initPd), .vidStopReq(vidStopReq),
        .powerGoodOrDownPin(powerGoodOrDownPin), .videoClkStopN(videoClkStopN));

    cpvg_ctrl #(.WAKE_LIMIT(200)) cpvg_ctrl_inst (.sys_clk(sysClk), .srst(srst),
        .powerGoodOrDownPin(powerGoodOrDownPin), .videoClkStopN(videoClkStopN),
        .cpuClkIn(cpuClkIn), .seClkIn(seClkIn), .diffClkIn(diffClkIn), .vid27In(vid27In),
        .vidSsIn(vid27In), .vidNssIn(vid27In), .pllLocked(pllLocked),
        .seClkOut(seClkOut), .vidSsOut(vidSsOut), .vidNssOut(vidNssOut),
        .diffTrueOut(diffTrueOut), .diffCompOut(diffCompOut), .diffOe(diffOe),
        .vcoEnable(vcoEnable), .xtalEnable(xtalEnable), .powerGood(powerGood),
        .wakeOverrun(wakeOverrun));

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // running: some high and some low cycles; stopped: never high
    task automatic window(input int n, input int eSe, input int eVid, input int eDiff);
        int hs = 0;
        int hv = 0;
        int hd = 0;
        int hc = 0;
        repeat (n) begin
            @(negedge sysClk);
            hs += seClkOut;
            hv += vidSsOut;
            hd += diffTrueOut;
            hc += diffCompOut;
        end
        chk(eDiff ? (hc > 0 && hc < n) : (hc != 0), eDiff);
        chk(eSe ? (hs > 0 && hs < n) : (hs != 0), eSe);
        chk(eVid ? (hv > 0 && hv < n) : (hv != 0), eVid);
        chk(eDiff ? (hd > 0 && hd < n) : (hd != 0), eDiff);
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // pulse widths of the registered outputs, parking order
    always @(negedge sysClk) begin
        if (!srst) chk($isunknown({seClkOut, vidSsOut, vidNssOut, diffTrueOut, diffCompOut,
                                   diffOe, vcoEnable, xtalEnable, powerGood, wakeOverrun}),
                       1'b0);
        seLen  <= seClkOut ? seLen + 1 : 0;
        vidLen <= vidSsOut ? vidLen + 1 : 0;
        if (!srst && !seClkOut && seLen != 0) chk(seLen, 3);
        if (!srst && !vidSsOut && vidLen != 0) chk(vidLen, 4);
        if (!srst) chk(vidNssOut, vidSsOut);
        if (!srst && !vcoEnable) chk({seClkOut, vidSsOut, diffTrueOut}, 3'h0);
    end

    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nMismatch++;
            $display("Error at %0t: timeout", $time);
            printVerdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(85));
        repeat (8) @(posedge sysClk);
        @(negedge sysClk) srst = 1'b0;
        chk({seClkOut, vidSsOut, vidNssOut, diffTrueOut, diffOe, vcoEnable, xtalEnable,
             powerGood, wakeOverrun}, 9'h01c);
        repeat (30) @(negedge sysClk);
        chk({powerGood, vcoEnable}, 2'h1);
        $display("test reset done");
        initPd <= 1'b1;
        pgReq <= 1'b1;
        pllLocked = 1'b1;
        for (int i = 0; i < 600 && vcoEnable; i++) @(negedge sysClk);
        chk({powerGood, vcoEnable, xtalEnable, diffOe, diffCompOut}, 5'h10);
        window(40, 0, 0, 0);
        $display("test initial power-down done");
        pllLocked = 1'b0;
        initPd <= 1'b0;
        repeat (6) @(negedge sysClk);
        chk({diffOe, diffTrueOut, vcoEnable, xtalEnable}, 4'hf);
        repeat ($urandom_range(30, 2)) @(negedge sysClk);
        pllLocked = 1'b1;
        repeat (20) @(negedge sysClk);
        window(60, 1, 1, 1);
        chk(wakeOverrun, 1'b0);
        $display("test wake done");
        repeat ($urandom_range(7, 0)) @(negedge sysClk);
        vidStopReq <= 1'b1;
        repeat (24) @(negedge sysClk);
        window(48, 1, 0, 1);
        vidStopReq <= 1'b0;
        for (int i = 0; i < 18 && !vidSsOut; i++) @(negedge sysClk);
        chk(vidSsOut, 1'b1);
        window(40, 1, 1, 1);
        $display("test video stop done");
        pdReq <= 1'b1;
        repeat (3) @(negedge sysClk);
        pdReq <= 1'b0;
        window(30, 1, 1, 1);
        pdReq <= 1'b1;
        for (int i = 0; i < 60 && vcoEnable; i++) @(negedge sysClk);
        chk({vcoEnable, xtalEnable, diffOe, diffCompOut}, 4'h0);
        window(30, 0, 0, 0);
        $display("test power-down done");
        printVerdict();
    end
endmodule
